// file: common/pph_pkg.sv
// Purpose: Constants for the plate preheat demand block
// Assumes: 100 MHz pclk, APB register access, one-second time base
// Notes:   Temperatures are signed Q12.4 degrees, times are seconds
//
// Operation
// - While idle and tap demand is on, the post-tap delay reloads and holds.
// - While idle and tap demand is off, the post-tap delay counts down.
// - Preheat cannot start before the post-tap delay has run out.
// - The on threshold is the preheat setpoint minus the on hysteresis.
// - Preheat starts when tap off, delay done and temp <= on threshold held for the recognition time.
// - The recognition timer clears when any entry condition fails and counts while all hold.
// - When recognition runs out, preheat goes active and drives plate demand.
// - At preheat start the tap-during-preheat flag clears and the minute timer is idle.
// - At preheat start a minimum-on timer starts and holds preheat on until it expires or conversion; the code also drops preheat when enabled goes low.
// - Losing burner priority restarts the minimum-on timer for a full period.
// - The off threshold is the preheat setpoint plus the off hysteresis.
// - Preheat ends on tap-during-preheat conversion, or temp >= off threshold with minimum-on expired.
// - While active the preheat setpoint is the hot-water setpoint and the threshold basis.
// - With the tap flag set, inlet below its start value and minute timer idle, start the minute timer.
// - On conversion a set event goes to tap demand and preheat drops.

package pph_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_SETPOINT  = 8'h04;
    localparam logic [7:0] ADDR_ON_HYST   = 8'h08;
    localparam logic [7:0] ADDR_OFF_HYST  = 8'h0C;
    localparam logic [7:0] ADDR_DELAY     = 8'h10;
    localparam logic [7:0] ADDR_RECOG     = 8'h14;
    localparam logic [7:0] ADDR_MIN_ON    = 8'h18;
    localparam logic [7:0] ADDR_STATUS    = 8'h1C;
    localparam logic [7:0] ADDR_HW_SP     = 8'h20;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int CTRL_EN_BIT        = 0;
    localparam int CTRL_SP_NONE_BIT   = 1;
    localparam int CTRL_ONH_NONE_BIT  = 2;
    localparam int CTRL_OFFH_NONE_BIT = 3;
    localparam int CTRL_W             = 4;
    localparam int ST_ACTIVE_BIT      = 0;
    localparam int ST_DEMAND_BIT      = 1;
    localparam int ST_DELAY_BIT       = 2;
    localparam int ST_FLAG_BIT        = 3;
    localparam int ST_MINUTE_BIT      = 4;
    localparam int ST_MIN_ON_BIT      = 5;
    localparam int ST_RECOG_BIT       = 6;
    localparam int TEMP_W             = 16;
    localparam int TIME_W             = 16;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [CTRL_W-1:0] CTRL_RST     = 4'h0;
    localparam logic [TEMP_W-1:0] SETPOINT_RST = 16'h0000;
    localparam logic [TEMP_W-1:0] HYST_RST     = 16'h0000;
    localparam logic [TIME_W-1:0] TIME_RST     = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_S = 1;
    localparam int TICK_CYCLES   = TICK_PERIOD_S * 1000000000 / CLK_PERIOD_NS;
    localparam logic [TIME_W-1:0] MINUTE_S = 16'h003C;

    // ------------------------------------------------------------
    // Preheat states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ON   = 2'b10
    } pph_state_t;

endpackage

// file: logic/pph_tick.sv
// Purpose: One-second tick generator
// Assumes: pclk at the package clock rate
// Notes:   TICK_CYCLES may be shortened for simulation

`timescale 1ns/1ps

module pph_tick #(
    parameter int TICK_CYCLES = pph_pkg::TICK_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    logic [31:0] cnt_ff;
    logic        tick_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff  <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (cnt_ff == 32'(TICK_CYCLES - 1)) begin
            cnt_ff  <= 32'h0000_0000;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff  <= cnt_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

    assign tick = tick_ff;

endmodule

// file: logic/pph_timer.sv
// Purpose: Seconds down-counter with reload-and-hold
// Assumes: tick is a one-cycle pulse per second
// Notes:   A zero length means None: done right after load

`timescale 1ns/1ps

module pph_timer #(
    parameter bit DONE_AT_RESET = 1'b0
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       load,
    input  wire logic                       run,
    input  wire logic                       tick,
    input  wire logic [pph_pkg::TIME_W-1:0] len,
    output logic                            done
);

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    logic [pph_pkg::TIME_W-1:0] cnt_ff;
    logic                       armed_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff   <= 16'h0000;
            armed_ff <= DONE_AT_RESET;
        end else if (load) begin
            cnt_ff   <= len;
            armed_ff <= 1'b1;
        end else if (run && tick && cnt_ff != 16'h0000) begin
            cnt_ff   <= cnt_ff - 16'h0001;
        end
    end

    assign done = armed_ff && (cnt_ff == 16'h0000);

endmodule

// file: logic/pph_top.sv
// Purpose: Plate preheat demand with APB configuration
// Assumes: Inputs synchronous to pclk, APB master per protocol
// Notes:   Slave answers with no wait states

`timescale 1ns/1ps

module pph_top #(
    parameter int TICK_CYCLES = pph_pkg::TICK_CYCLES
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic [7:0]                 paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       tap_demand,
    input  wire logic                       priority_grant,
    input  wire logic [pph_pkg::TEMP_W-1:0] hot_water_temp,
    input  wire logic [pph_pkg::TEMP_W-1:0] inlet_temp,
    input  wire logic [pph_pkg::TEMP_W-1:0] normal_setpoint,
    output logic                            preheat_active,
    output logic                            plate_demand,
    output logic                            tap_set,
    output logic [pph_pkg::TEMP_W-1:0]      hot_water_setpoint
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [pph_pkg::CTRL_W-1:0] ctrl_ff;
    logic [pph_pkg::TEMP_W-1:0] setpoint_ff;
    logic [pph_pkg::TEMP_W-1:0] on_hyst_ff;
    logic [pph_pkg::TEMP_W-1:0] off_hyst_ff;
    logic [pph_pkg::TIME_W-1:0] delay_len_ff;
    logic [pph_pkg::TIME_W-1:0] recog_len_ff;
    logic [pph_pkg::TIME_W-1:0] min_on_len_ff;
    logic [31:0]                prdata_ff;
    logic                       pslverr_ff;
    pph_pkg::pph_state_t        state_ff;
    pph_pkg::pph_state_t        nxt_state;
    logic                       tap_flag_ff;
    logic                       minute_run_ff;
    logic [pph_pkg::TEMP_W-1:0] inlet_cap_ff;
    logic                       tap_set_ff;
    logic [pph_pkg::TEMP_W-1:0] hw_sp_ff;
    logic                       tick;
    logic                       delay_done;
    logic                       recog_done;
    logic                       min_on_done;
    logic                       minute_done;
    logic                       is_idle;
    logic                       is_on;
    logic                       enabled;
    logic                       addr_ok;
    logic                       wr_en;
    logic signed [16:0]         sp_s;
    logic signed [16:0]         onh_s;
    logic signed [16:0]         offh_s;
    logic signed [16:0]         on_thr;
    logic signed [16:0]         off_thr;
    logic signed [16:0]         hw_s;
    logic                       below_on;
    logic                       above_off;
    logic                       entry_ok;
    logic                       start_pre;
    logic                       minute_start;
    logic                       convert;
    logic                       normal_end;
    logic [31:0]                status_w;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    always_comb begin
        case (paddr)
            pph_pkg::ADDR_CTRL,     pph_pkg::ADDR_SETPOINT,
            pph_pkg::ADDR_ON_HYST,  pph_pkg::ADDR_OFF_HYST,
            pph_pkg::ADDR_DELAY,    pph_pkg::ADDR_RECOG,
            pph_pkg::ADDR_MIN_ON,   pph_pkg::ADDR_STATUS,
            pph_pkg::ADDR_HW_SP:    addr_ok = 1'b1;
            default:                addr_ok = 1'b0;
        endcase
    end

    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign pready  = 1'b1;
    assign prdata  = prdata_ff;
    assign pslverr = pslverr_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff       <= pph_pkg::CTRL_RST;
            setpoint_ff   <= pph_pkg::SETPOINT_RST;
            on_hyst_ff    <= pph_pkg::HYST_RST;
            off_hyst_ff   <= pph_pkg::HYST_RST;
            delay_len_ff  <= pph_pkg::TIME_RST;
            recog_len_ff  <= pph_pkg::TIME_RST;
            min_on_len_ff <= pph_pkg::TIME_RST;
        end else if (wr_en) begin
            case (paddr)
                pph_pkg::ADDR_CTRL:     ctrl_ff <= pwdata[pph_pkg::CTRL_W-1:0];
                pph_pkg::ADDR_SETPOINT: setpoint_ff   <= pwdata[15:0];
                pph_pkg::ADDR_ON_HYST:  on_hyst_ff    <= pwdata[15:0];
                pph_pkg::ADDR_OFF_HYST: off_hyst_ff   <= pwdata[15:0];
                pph_pkg::ADDR_DELAY:    delay_len_ff  <= pwdata[15:0];
                pph_pkg::ADDR_RECOG:    recog_len_ff  <= pwdata[15:0];
                pph_pkg::ADDR_MIN_ON:   min_on_len_ff <= pwdata[15:0];
                default:                ;
            endcase
        end
    end

    assign status_w = {25'h0, recog_done, min_on_done, minute_run_ff,
                       tap_flag_ff, delay_done, is_on, is_on};

    // Read data captured in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_ff <= !addr_ok;
            case (paddr)
                pph_pkg::ADDR_CTRL:     prdata_ff <= {28'h0, ctrl_ff};
                pph_pkg::ADDR_SETPOINT: prdata_ff <= {16'h0, setpoint_ff};
                pph_pkg::ADDR_ON_HYST:  prdata_ff <= {16'h0, on_hyst_ff};
                pph_pkg::ADDR_OFF_HYST: prdata_ff <= {16'h0, off_hyst_ff};
                pph_pkg::ADDR_DELAY:    prdata_ff <= {16'h0, delay_len_ff};
                pph_pkg::ADDR_RECOG:    prdata_ff <= {16'h0, recog_len_ff};
                pph_pkg::ADDR_MIN_ON:   prdata_ff <= {16'h0, min_on_len_ff};
                pph_pkg::ADDR_STATUS:   prdata_ff <= status_w;
                pph_pkg::ADDR_HW_SP:    prdata_ff <= {16'h0, hw_sp_ff};
                default:                prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Thresholds
    // ------------------------------------------------------------
    assign enabled = ctrl_ff[pph_pkg::CTRL_EN_BIT]
                     && !ctrl_ff[pph_pkg::CTRL_SP_NONE_BIT];
    assign sp_s    = {setpoint_ff[15], setpoint_ff};
    assign onh_s   = ctrl_ff[pph_pkg::CTRL_ONH_NONE_BIT] ? 17'h00000
                     : {on_hyst_ff[15], on_hyst_ff};
    assign offh_s  = ctrl_ff[pph_pkg::CTRL_OFFH_NONE_BIT] ? 17'h00000
                     : {off_hyst_ff[15], off_hyst_ff};
    assign hw_s    = {hot_water_temp[15], hot_water_temp};
    assign on_thr  = sp_s - onh_s;
    assign off_thr = sp_s + offh_s;
    assign below_on  = hw_s <= on_thr;
    assign above_off = hw_s >= off_thr;

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    pph_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    assign is_idle = (state_ff == pph_pkg::ST_IDLE);
    assign is_on   = (state_ff == pph_pkg::ST_ON);

    pph_timer #(.DONE_AT_RESET(1'b1)) u_delay (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (is_idle && tap_demand),
        .run     (is_idle && !tap_demand),
        .tick    (tick),
        .len     (delay_len_ff),
        .done    (delay_done)
    );

    assign entry_ok  = !tap_demand && delay_done && below_on;
    assign start_pre = is_idle && enabled && entry_ok && recog_done;

    pph_timer #(.DONE_AT_RESET(1'b0)) u_recog (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (!is_idle || !entry_ok),
        .run     (is_idle && entry_ok),
        .tick    (tick),
        .len     (recog_len_ff),
        .done    (recog_done)
    );

    pph_timer #(.DONE_AT_RESET(1'b0)) u_min_on (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (!is_on || !priority_grant),
        .run     (is_on && priority_grant),
        .tick    (tick),
        .len     (min_on_len_ff),
        .done    (min_on_done)
    );

    assign minute_start = is_on && tap_flag_ff && !minute_run_ff
                          && ($signed(inlet_temp) < $signed(inlet_cap_ff));

    pph_timer #(.DONE_AT_RESET(1'b0)) u_minute (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (minute_start),
        .run     (minute_run_ff),
        .tick    (tick),
        .len     (pph_pkg::MINUTE_S),
        .done    (minute_done)
    );

    // ------------------------------------------------------------
    // Preheat state
    // ------------------------------------------------------------
    assign normal_end = above_off && min_on_done;
    assign convert    = is_on && tap_flag_ff
                        && ((minute_run_ff && minute_done)
                            || ($signed(hot_water_temp)
                                >= $signed(inlet_temp))
                            || normal_end);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            pph_pkg::ST_IDLE: begin
                if (start_pre) begin
                    nxt_state = pph_pkg::ST_ON;
                end
            end
            pph_pkg::ST_ON: begin
                if (!enabled || convert || normal_end) begin
                    nxt_state = pph_pkg::ST_IDLE;
                end
            end
            default: nxt_state = pph_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= pph_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Tap-during-preheat flag and minute timer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tap_flag_ff   <= 1'b0;
            minute_run_ff <= 1'b0;
            inlet_cap_ff  <= 16'h0000;
        end else if (start_pre) begin
            tap_flag_ff   <= 1'b0;
            minute_run_ff <= 1'b0;
            inlet_cap_ff  <= inlet_temp;
        end else if (is_on) begin
            if (tap_demand) begin
                tap_flag_ff <= 1'b1;
            end
            if (minute_start) begin
                minute_run_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tap_set_ff <= 1'b0;
        end else begin
            tap_set_ff <= convert;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hw_sp_ff <= 16'h0000;
        end else begin
            hw_sp_ff <= (nxt_state == pph_pkg::ST_ON) ? setpoint_ff
                        : normal_setpoint;
        end
    end

    assign preheat_active     = is_on;
    assign plate_demand       = is_on;
    assign tap_set            = tap_set_ff;
    assign hot_water_setpoint = hw_sp_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    delay_hold_a: assert property (
        is_idle && tap_demand && delay_len_ff != 16'h0000 |=> !delay_done
    ) else $error("post-tap delay not held during tap demand");

    delay_run_a: assert property (
        is_idle && !tap_demand && tick && u_delay.cnt_ff != 16'h0000
        |=> u_delay.cnt_ff == $past(u_delay.cnt_ff) - 16'h0001
    ) else $error("post-tap delay not running");

    delay_block_a: assert property (
        is_idle && !delay_done |=> is_idle
    ) else $error("preheat started before post-tap delay");

    entry_a: assert property (
        $rose(preheat_active) |-> $past(entry_ok && recog_done && enabled)
    ) else $error("preheat started without entry conditions");

    recog_clr_a: assert property (
        is_idle && !entry_ok && recog_len_ff != 16'h0000 |=> !recog_done
    ) else $error("recognition timer not cleared");

    start_a: assert property (
        start_pre |=> preheat_active && plate_demand
    ) else $error("preheat not asserted after recognition");

    flag_clr_a: assert property (
        $rose(preheat_active) |-> !tap_flag_ff && !minute_run_ff
    ) else $error("tap flag not cleared at preheat start");

    min_on_a: assert property (
        is_on && !min_on_done && !convert && enabled |=> is_on
    ) else $error("preheat ended before minimum on time");

    restart_a: assert property (
        is_on && !priority_grant && min_on_len_ff != 16'h0000
        |=> !min_on_done
    ) else $error("minimum on timer not restarted");

    exit_a: assert property (
        is_on && above_off && min_on_done |=> is_idle
    ) else $error("preheat did not end at off threshold");

    setpoint_a: assert property (
        preheat_active |-> hot_water_setpoint == setpoint_ff
                           || $changed(setpoint_ff)
    ) else $error("hot water setpoint not preheat setpoint");

    minute_a: assert property (
        minute_start |=> minute_run_ff ##0 !minute_done
                         || pph_pkg::MINUTE_S == 16'h0000
    ) else $error("minute timer not started");

    convert_a: assert property (
        convert |=> tap_set && !preheat_active
    ) else $error("conversion did not hand over to tap demand");

    start_c:    cover property ($rose(preheat_active));
    convert_c:  cover property (tap_set);
    restart_c:  cover property (is_on ##1 !priority_grant ##1 priority_grant);

endmodule

// file: dv/pph_partner.sv
// Purpose: Tap demand block and burner arbiter model
// Assumes: Driven by the bench through tap_req and deny
// Notes:   A set event holds tap demand for 15 cycles

`timescale 1ns/1ps

module pph_partner (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic tap_set,
    input  wire logic tap_req,
    input  wire logic deny,
    output logic      tap_demand,
    output logic      priority_grant
);
    // ----------------------------------------
    // Tap demand minimum on after set
    // ----------------------------------------
    logic [3:0] hold_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_ff <= 4'h0;
        end else if (tap_set) begin
            hold_ff <= 4'hF;
        end else if (hold_ff != 4'h0) begin
            hold_ff <= hold_ff - 4'h1;
        end
    end

    assign tap_demand     = tap_req | (hold_ff != 4'h0);
    assign priority_grant = ~deny;
endmodule

// file: dv/test_plate_preheat_demand.sv
// Purpose: Self-checking bench for the preheat demand block
// Assumes: One tick every 10 cycles, APB with zero wait states
// Notes:   Temperatures are Q12.4, setpoint 50.0, hysteresis 5.0

`timescale 1ns/1ps

module test_plate_preheat_demand;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, e, tap_req = 1'b0, deny = 1'b0;
    logic        tap_demand, priority_grant, preheat_active;
    logic        plate_demand, tap_set;
    logic [15:0] hot_water_temp = 16'h0400, inlet_temp = 16'h0600;
    logic [15:0] normal_setpoint = 16'h0280, hot_water_setpoint;
    int          miscompares = 0, compares = 0;
    logic [7:0]  ad [7] = '{pph_pkg::ADDR_SETPOINT, pph_pkg::ADDR_ON_HYST,
        pph_pkg::ADDR_OFF_HYST, pph_pkg::ADDR_DELAY, pph_pkg::ADDR_RECOG,
        pph_pkg::ADDR_MIN_ON, pph_pkg::ADDR_CTRL};
    logic [31:0] wd [7] = '{32'h320, 32'h50, 32'h50, 32'h2, 32'h1, 32'h3,
        32'h1};

    always #5 pclk = ~pclk;

    pph_top #(.TICK_CYCLES(10)) pph_top_i (.pclk, .presetn, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .tap_demand,
        .priority_grant, .hot_water_temp, .inlet_temp, .normal_setpoint,
        .preheat_active, .plate_demand, .tap_set, .hot_water_setpoint);

    pph_partner pph_partner_i (.pclk, .presetn, .tap_set, .tap_req, .deny,
        .tap_demand, .priority_grant);

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic complete_run;
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] x,
                       input logic [31:0] g);
        compares++;
        if (g !== x) begin
            $display("mismatch %s expected %h seen %h", n, x, g);
            miscompares++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_pa(input logic v);
        for (int i = 0; i < 150 && preheat_active !== v; i++) @(posedge pclk);
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        complete_run;
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) apb(1'b1, ad[i], wd[i]);
        apb(1'b0, pph_pkg::ADDR_SETPOINT, 32'h0);
        chk("setpoint", 32'h320, q);
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped err", 32'h1, e);
        chk("unmapped data", 32'h0, q);
        hot_water_temp <= 16'h02D0;
        tap_req <= 1'b1;
        repeat (40) @(posedge pclk);
        chk("active in tap", 32'h0, preheat_active);
        apb(1'b0, pph_pkg::ADDR_STATUS, 32'h0);
        chk("delay held", 32'h0, q[pph_pkg::ST_DELAY_BIT]);
        tap_req <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("active in delay", 32'h0, preheat_active);
        hot_water_temp <= 16'h02D1;
        repeat (60) @(posedge pclk);
        chk("active above on", 32'h0, preheat_active);
        hot_water_temp <= 16'h02D0;
        wait_pa(1'b1);
        chk("active start", 32'h1, preheat_active);
        chk("plate demand", 32'h1, plate_demand);
        @(posedge pclk);
        chk("hw setpoint on", 32'h320, hot_water_setpoint);
        hot_water_temp <= 16'h0370;
        repeat (15) @(posedge pclk);
        chk("active min on", 32'h1, preheat_active);
        deny <= 1'b1;
        repeat (50) @(posedge pclk);
        chk("active denied", 32'h1, preheat_active);
        deny <= 1'b0;
        repeat (15) @(posedge pclk);
        chk("active regrant", 32'h1, preheat_active);
        wait_pa(1'b0);
        chk("active at off", 32'h0, preheat_active);
        repeat (2) @(posedge pclk);
        chk("hw setpoint off", 32'h280, hot_water_setpoint);
        hot_water_temp <= 16'h02D0;
        wait_pa(1'b1);
        tap_req <= 1'b1;
        repeat (3) @(posedge pclk);
        tap_req <= 1'b0;
        inlet_temp <= 16'h0200;
        for (int i = 0; i < 20 && tap_set !== 1'b1; i++) @(posedge pclk);
        chk("tap set", 32'h1, tap_set);
        chk("active conv", 32'h0, preheat_active);
        @(posedge pclk);
        chk("tap demand", 32'h1, tap_demand);
        inlet_temp <= 16'h0600;
        wait_pa(1'b1);
        apb(1'b0, pph_pkg::ADDR_STATUS, 32'h0);
        chk("tap flag", 32'h0, q[pph_pkg::ST_FLAG_BIT]);
        chk("minute idle", 32'h0, q[pph_pkg::ST_MINUTE_BIT]);
        apb(1'b1, pph_pkg::ADDR_CTRL, 32'h3);
        repeat (2) @(posedge pclk);
        chk("active disabled", 32'h0, preheat_active);
        hot_water_temp <= 16'h031F;
        apb(1'b1, pph_pkg::ADDR_CTRL, 32'h5);
        wait_pa(1'b1);
        chk("active on none", 32'h1, preheat_active);
        hot_water_temp <= 16'h0320;
        apb(1'b1, pph_pkg::ADDR_CTRL, 32'h9);
        wait_pa(1'b0);
        chk("active off none", 32'h0, preheat_active);
        complete_run;
    end
endmodule
